/* rtl/hale_consts.svh */
// Constants for the HDLC auto-mode link engine: offsets, fields, resets, times.
// Assumes inclusion from the package, the design modules and the testbench.
`ifndef HALE_CONSTS_SVH
`define HALE_CONSTS_SVH
`define HALE_OFF_MODE    8'h00
`define HALE_OFF_CMD     8'h04
`define HALE_OFF_TIMER   8'h08
`define HALE_OFF_STATUS  8'h0c
`define HALE_OFF_EVENT   8'h10
`define HALE_OFF_TXDATA  8'h14
`define HALE_OFF_RXDATA  8'h18
`define HALE_OFF_ADRLOW  8'h1c
`define HALE_OFF_ADRHIGH 8'h20
`define HALE_OFF_CHANNEL_CONFIG_THREE    8'h24
`define HALE_OFF_LINE    8'h28
// Mode register fields
`define HALE_MODE_MODE_SELECT_LOW   0
`define HALE_MODE_MODE_SELECT_HIGH   1
`define HALE_MODE_ADM    2
`define HALE_MODE_TMD    3
`define HALE_MODE_RNR    4
`define HALE_MODE_RESET  8'h00
// Command register bits (write one to issue)
`define HALE_CMD_XIF     0
`define HALE_CMD_XTF     1
`define HALE_CMD_RHR     2
`define HALE_CMD_XRES    3
// Mode codes
`define HALE_MDS_AUTO    2'b00
`define HALE_MDS_NONAUTO 2'b01
`define HALE_MDS_TRANS   2'b10
`define HALE_MDS_EXT     2'b11
// Timer register: period [15:0] in units, retry count [19:16]
`define HALE_TIMER_RESET 32'h0003_0010
`define HALE_TUNIT_NS    1000
`define HALE_CLK_NS      25
`define HALE_TUNIT_CYC   ((`HALE_TUNIT_NS + `HALE_CLK_NS - 1) / `HALE_CLK_NS)
// Event bits
`define HALE_EV_ALL_SENT_EVENT     0
`define HALE_EV_XMR      1
`define HALE_EV_TIN      2
`define HALE_EV_XPR      3
`define HALE_EV_RSC      4
`define HALE_EV_PCE      5
`define HALE_EV_RME      6
// Frame kinds on the line port
`define HALE_FK_I        3'd0
`define HALE_FK_RR       3'd1
`define HALE_FK_RNR      3'd2
`define HALE_FK_REJ      3'd3
`define HALE_FK_U        3'd4
`define HALE_FK_TRANS    3'd5
`define HALE_FIFO_DEPTH  64
`define HALE_FIFO_AW     6
`endif

/* rtl/hale_pkg.sv */
// Types for the HDLC auto-mode link engine.
// Assumes hale_consts.svh is on the include path.
`include "hale_consts.svh"
package hale_pkg;
  typedef enum logic [2:0] {
    HALE_IDLE, HALE_SEND, HALE_WAIT_ACK, HALE_POLL, HALE_TAIL
  } hale_st_t;
  typedef logic [7:0] hale_byte_t;
endpackage : hale_pkg

/* rtl/hale_fifo_mem.sv */
// Byte memory for one queue, read data registered.
// Assumes one write and one read port on sys_clk.
`timescale 1ns/1ps
`include "hale_consts.svh"
module hale_fifo_mem (
  input  wire logic                   sys_clk,
  input  wire logic                   we,
  input  wire logic [`HALE_FIFO_AW-1:0] waddr,
  input  wire logic [7:0]             wdata,
  input  wire logic [`HALE_FIFO_AW-1:0] raddr,
  output logic      [7:0]             rdata
);
  logic [7:0] mem [`HALE_FIFO_DEPTH];
  // Plain synchronous RAM, no reset needed on contents
  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : hale_fifo_mem

/* rtl/hale_link_engine.sv */
// HDLC channel auto-mode layer-2 engine with APB registers and byte line port.
// Assumes a framer outside handles flags/CRC and presents decoded frames.
`timescale 1ns/1ps
`include "hale_consts.svh"
module hale_link_engine (
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          rx_valid,
  input  wire logic [2:0]    rx_kind,
  input  wire logic          rx_pf,
  input  wire logic [6:0]    rx_ns,
  input  wire logic [6:0]    rx_nr,
  input  wire logic          rx_ifield,
  input  wire logic          rx_byte_valid,
  input  wire logic [7:0]    rx_byte,
  output logic               tx_valid,
  output logic      [7:0]    tx_byte,
  input  wire logic          tx_ready,
  output logic               tx_start,
  output logic      [2:0]    tx_kind,
  output logic               tx_pf,
  output logic      [6:0]    tx_ns,
  output logic      [6:0]    tx_nr,
  output logic               tx_raw,
  output logic               tx_no_crc
);
  import hale_pkg::*;

  typedef struct packed {
    logic [7:0]  mode;
    logic [31:0] timer;
    logic [7:0]  adr_high;
    logic [7:0]  channel_config_three;
    logic [6:0]  ev;
    logic [7:0]  adr_low;
    hale_st_t    st;
    logic        tx_is_i;
    logic [6:0]  vs;
    logic [6:0]  vr;
    logic        remote_busy;
    logic [15:0] unit_cnt;
    logic [15:0] per_cnt;
    logic [3:0]  tries;
    logic [6:0]  txw;
    logic [6:0]  txr;
    logic [6:0]  rxw;
    logic [6:0]  rxr;
    logic        tx_blocked;
    logic        tx_go;
    logic        s_pend;
    logic [2:0]  s_kind;
    logic        s_pf;
    logic [7:0]  tx_data;
    logic        tx_v;
    logic [31:0] rdata;
    logic        rd_done;
    logic [6:0]  txw_vis;
  } hale_state_t;

  hale_state_t state_reg;
  hale_state_t state_next;
  logic [7:0]  txq_rd;
  logic [7:0]  rxq_rd;
  logic        apb_wr;
  logic        apb_rd;
  logic        txq_full;
  logic        rxq_full;
  logic        txq_we;
  logic        rxq_we;
  logic        in_ext;
  logic        in_auto;

  assign apb_wr  = psel & penable & pwrite;
  assign apb_rd  = psel & penable & ~pwrite & ~state_reg.rd_done;
  assign in_ext  = state_reg.mode[`HALE_MODE_MODE_SELECT_HIGH] &
                   state_reg.mode[`HALE_MODE_MODE_SELECT_LOW];
  assign in_auto = ~state_reg.mode[`HALE_MODE_MODE_SELECT_HIGH] &
                   ~state_reg.mode[`HALE_MODE_MODE_SELECT_LOW];
  assign txq_full = (state_reg.txw - state_reg.txr) == 7'h40;
  assign rxq_full = (state_reg.rxw - state_reg.rxr) == 7'h40;
  assign txq_we = apb_wr && paddr == `HALE_OFF_TXDATA && !txq_full;
  // Extended mode 1 and every framed mode feed the receive queue
  assign rxq_we = rx_byte_valid && !rxq_full &&
                  (!in_ext || state_reg.mode[`HALE_MODE_ADM]);

  hale_fifo_mem u_txq (
    .sys_clk (sys_clk),
    .we      (txq_we),
    .waddr   (state_reg.txw[5:0]),
    .wdata   (pwdata[7:0]),
    .raddr   (state_next.txr[5:0]),
    .rdata   (txq_rd)
  );

  hale_fifo_mem u_rxq (
    .sys_clk (sys_clk),
    .we      (rxq_we),
    .waddr   (state_reg.rxw[5:0]),
    .wdata   (rx_byte),
    .raddr   (state_next.rxr[5:0]),
    .rdata   (rxq_rd)
  );

  // Writes end at once; reads take one wait state so the data stands
  // in a register at the edge where pready is sampled
  assign pready  = ~(psel & penable & ~pwrite) | state_reg.rd_done;
  assign pslverr = 1'b0;
  assign prdata  = state_reg.rdata;

  // Line outputs come straight from state
  assign tx_valid  = state_reg.tx_v;
  assign tx_byte   = state_reg.tx_data;
  assign tx_raw    = in_ext;
  assign tx_no_crc = state_reg.channel_config_three[0];

  // Frame starts: S frames win over queued data
  always_comb begin
    tx_start = 1'b0;
    tx_kind  = `HALE_FK_RR;
    tx_pf    = 1'b0;
    tx_ns    = state_reg.vs;
    tx_nr    = state_reg.vr;
    if (state_reg.s_pend) begin
      tx_start = 1'b1;
      tx_kind  = state_reg.s_kind;
      tx_pf    = state_reg.s_pf;
    end else if (state_reg.tx_go) begin
      tx_start = 1'b1;
      tx_kind  = state_reg.tx_is_i ? `HALE_FK_I : `HALE_FK_TRANS;
    end
  end

  // Main next-state logic
  always_comb begin
    logic [6:0]  msk;
    logic        acked;
    logic        tick;
    logic        expire;
    logic [6:0]  ev_clr;
    state_next = state_reg;
    // Events gather this cycle's sets only; merged with clears at the end
    state_next.ev = 7'h00;
    ev_clr = 7'h00;
    state_next.rd_done = apb_rd;
    state_next.txw_vis = state_reg.txw;
    msk = state_reg.adr_high[0] ? 7'h7f : 7'h07;
    acked = 1'b0;
    tick = 1'b0;
    expire = 1'b0;
    if (tx_start) begin
      state_next.s_pend = 1'b0;
      if (!state_reg.s_pend) begin
        state_next.tx_go = 1'b0;
      end
    end
    // Timer base: one unit per period count
    if (state_reg.st == HALE_WAIT_ACK || state_reg.st == HALE_POLL ||
        state_reg.st == HALE_TAIL) begin
      if (state_reg.unit_cnt == 16'(`HALE_TUNIT_CYC - 1)) begin
        state_next.unit_cnt = 16'h0000;
        tick = 1'b1;
      end else begin
        state_next.unit_cnt = state_reg.unit_cnt + 16'h0001;
      end
      if (tick) begin
        if (state_reg.per_cnt >= state_reg.timer[15:0]) begin
          state_next.per_cnt = 16'h0000;
          expire = 1'b1;
        end else begin
          state_next.per_cnt = state_reg.per_cnt + 16'h0001;
        end
      end
    end
    // Transmit byte stream; the length is never judged here
    if (state_reg.tx_v && tx_ready) begin
      state_next.tx_v = 1'b0;
    end
    // Bytes leave only after the frame start, or freely in extended mode;
    // a byte counts a cycle after its write, once the read port holds it
    if ((!state_reg.tx_v || tx_ready) && !state_reg.tx_blocked &&
        (in_ext || (state_reg.st == HALE_SEND && !state_reg.tx_go)) &&
        state_reg.txw_vis != state_reg.txr) begin
      state_next.tx_data = txq_rd;
      state_next.tx_v = 1'b1;
      state_next.txr = state_reg.txr + 7'h01;
      if (state_reg.txw_vis - state_reg.txr == 7'h01) begin
        if (state_reg.st == HALE_SEND && state_reg.tx_is_i) begin
          state_next.tx_blocked = 1'b1;
          state_next.st = HALE_WAIT_ACK;
          state_next.unit_cnt = 16'h0000;
          state_next.per_cnt = 16'h0000;
          state_next.tries = 4'h0;
        end else begin
          state_next.ev[`HALE_EV_XPR] = 1'b1;
          if (state_reg.st == HALE_SEND) begin
            state_next.st = HALE_IDLE;
          end
        end
      end
    end
    // Receive byte into low-address compare register
    if (rx_byte_valid && in_ext) begin
      state_next.adr_low = rx_byte;
    end
    if (rxq_we) begin
      state_next.rxw = state_reg.rxw + 7'h01;
    end
    // Received frames
    if (rx_valid && in_auto) begin
      if (rx_kind == `HALE_FK_U) begin
        state_next.ev[`HALE_EV_RME] = 1'b1;
      end else begin
        // Window one: N(R) ack means LSB differs from the local send count vs
        acked = (rx_nr[0] != state_reg.vs[0]);
        if (rx_kind == `HALE_FK_I) begin
          if (state_reg.mode[`HALE_MODE_RNR]) begin
            state_next.s_pend = 1'b1;
            state_next.s_kind = `HALE_FK_RNR;
            state_next.s_pf = rx_pf;
          end else begin
            if (rx_ns[0] == state_reg.vr[0]) begin
              state_next.vr = (state_reg.vr + 7'h01) & msk;
              state_next.ev[`HALE_EV_RME] = 1'b1;
            end
            // Sequence errors are silently confirmed
            state_next.s_pend = 1'b1;
            state_next.s_kind = `HALE_FK_RR;
            state_next.s_pf = rx_pf;
          end
        end else begin
          if (rx_ifield) begin
            state_next.ev[`HALE_EV_PCE] = 1'b1;
          end
          if ((rx_kind == `HALE_FK_RNR) != state_reg.remote_busy) begin
            state_next.ev[`HALE_EV_RSC] = 1'b1;
          end
          state_next.remote_busy = (rx_kind == `HALE_FK_RNR);
          if (rx_kind == `HALE_FK_RNR && state_reg.st == HALE_IDLE) begin
            state_next.st = HALE_POLL;
            state_next.tx_blocked = 1'b1;
            state_next.unit_cnt = 16'h0000;
            state_next.per_cnt = 16'h0000;
            state_next.tries = 4'h0;
          end
          if (rx_pf && !rx_ifield) begin
            state_next.s_pend = 1'b1;
            state_next.s_kind = state_reg.mode[`HALE_MODE_RNR] ?
                                `HALE_FK_RNR : `HALE_FK_RR;
            state_next.s_pf = 1'b1;
          end
        end
        if (state_reg.st == HALE_WAIT_ACK || state_reg.st == HALE_POLL) begin
          if (acked && rx_kind != `HALE_FK_RNR) begin
            if (state_reg.st == HALE_WAIT_ACK) begin
              state_next.vs = (state_reg.vs + 7'h01) & msk;
            end
            state_next.ev[`HALE_EV_ALL_SENT_EVENT] = 1'b1;
            state_next.st = HALE_IDLE;
            state_next.tx_blocked = 1'b0;
          end else if (state_reg.st == HALE_POLL &&
                       rx_kind == `HALE_FK_REJ) begin
            state_next.ev[`HALE_EV_XMR] = 1'b1;
            state_next.st = HALE_IDLE;
            state_next.tx_blocked = 1'b0;
          end else if (rx_kind != `HALE_FK_RNR &&
                       state_reg.st == HALE_POLL && state_reg.tries != 0) begin
            state_next.ev[`HALE_EV_XMR] = 1'b1;
            state_next.st = HALE_IDLE;
            state_next.tx_blocked = 1'b0;
          end else if (!acked && rx_kind != `HALE_FK_I && rx_kind !=
                       `HALE_FK_RNR) begin
            state_next.ev[`HALE_EV_PCE] = 1'b1;
          end
        end
      end
    end else if (rx_valid && rx_kind == `HALE_FK_U) begin
      state_next.ev[`HALE_EV_RME] = 1'b1;
    end
    // Retry period expiry: poll with p set and count up tries; at the retry limit raise TIN, and in TAIL end the wait
    if (expire) begin
      if (state_reg.st == HALE_TAIL) begin
        state_next.ev[`HALE_EV_ALL_SENT_EVENT] = 1'b1;
        state_next.st = HALE_IDLE;
        state_next.tx_blocked = 1'b0;
      end else if (state_reg.tries >= state_reg.timer[19:16]) begin
        state_next.ev[`HALE_EV_TIN] = 1'b1;
        if (state_reg.remote_busy) begin
          state_next.st = HALE_TAIL;
        end else begin
          state_next.st = HALE_IDLE;
          state_next.tx_blocked = 1'b0;
        end
      end else begin
        state_next.tries = state_reg.tries + 4'h1;
        state_next.st = HALE_POLL;
        state_next.s_pend = 1'b1;
        state_next.s_kind = state_reg.mode[`HALE_MODE_RNR] ?
                            `HALE_FK_RNR : `HALE_FK_RR;
        state_next.s_pf = 1'b1;
      end
    end
    // Register writes
    if (apb_wr) begin
      unique case (paddr)
        `HALE_OFF_MODE:    state_next.mode = pwdata[7:0];
        `HALE_OFF_TIMER:   state_next.timer = pwdata;
        `HALE_OFF_ADRHIGH: state_next.adr_high = pwdata[7:0];
        `HALE_OFF_CHANNEL_CONFIG_THREE:    state_next.channel_config_three = pwdata[7:0];
        `HALE_OFF_TXDATA: begin
          if (!txq_full) begin
            state_next.txw = state_reg.txw + 7'h01;
          end
        end
        `HALE_OFF_EVENT: begin
          // Write one to clear; a same-cycle set survives
          ev_clr = pwdata[6:0];
        end
        `HALE_OFF_CMD: begin
          if (pwdata[`HALE_CMD_XIF] && in_auto) begin
            state_next.st = HALE_SEND;
            state_next.tx_is_i = 1'b1;
            state_next.tx_go = 1'b1;
          end else if (pwdata[`HALE_CMD_XTF]) begin
            state_next.st = HALE_SEND;
            state_next.tx_is_i = 1'b0;
            state_next.tx_go = 1'b1;
          end
          if (pwdata[`HALE_CMD_RHR]) begin
            state_next.vs = 7'h00;
            state_next.vr = 7'h00;
            state_next.remote_busy = 1'b0;
            state_next.st = HALE_IDLE;
            state_next.tx_blocked = 1'b0;
            state_next.s_pend = 1'b0;
          end
          if (pwdata[`HALE_CMD_XRES]) begin
            state_next.txw = 7'h00;
            state_next.txr = 7'h00;
            state_next.txw_vis = 7'h00;
            state_next.tx_v = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Register reads; receive data pops the queue
    if (apb_rd) begin
      unique case (paddr)
        `HALE_OFF_MODE:    state_next.rdata = {24'h0, state_reg.mode};
        `HALE_OFF_TIMER:   state_next.rdata = state_reg.timer;
        `HALE_OFF_ADRHIGH: state_next.rdata = {24'h0, state_reg.adr_high};
        `HALE_OFF_CHANNEL_CONFIG_THREE:    state_next.rdata = {24'h0, state_reg.channel_config_three};
        `HALE_OFF_ADRLOW:  state_next.rdata = {24'h0, state_reg.adr_low};
        `HALE_OFF_EVENT:   state_next.rdata = {25'h0, state_reg.ev};
        `HALE_OFF_STATUS:  state_next.rdata = {10'h0, state_reg.vs,
                              state_reg.vr, 2'h0, state_reg.remote_busy,
                              state_reg.tx_blocked, 1'b0, state_reg.st};
        `HALE_OFF_RXDATA: begin
          state_next.rdata = {24'h0, rxq_rd};
          if (state_reg.rxw != state_reg.rxr) begin
            state_next.rxr = state_reg.rxr + 7'h01;
          end
        end
        default: state_next.rdata = 32'h0000_0000;
      endcase
    end
    // Set wins over a same-cycle clear
    state_next.ev = (state_reg.ev & ~ev_clr) | state_next.ev;
  end

  // Single state register; reset gives an idle balanced station
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.mode <= `HALE_MODE_RESET;
      state_reg.timer <= `HALE_TIMER_RESET;
      state_reg.st <= HALE_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // I-frame send must block the queue while the ack is awaited
  block_on_i_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (state_reg.st == HALE_WAIT_ACK) |-> state_reg.tx_blocked)
    else $error("queue not blocked while waiting for ack");
  // Extended mode: each received byte shows in the compare register
  adr_low_byte_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (rx_byte_valid && in_ext) |=> state_reg.adr_low == $past(rx_byte))
    else $error("received byte missing from compare register");
  // Out-of-sequence I-frame: RR reply, nothing handed on
  seq_err_reply_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (rx_valid && in_auto && rx_kind == `HALE_FK_I && !apb_wr &&
     !state_reg.mode[`HALE_MODE_RNR] && rx_ns[0] != state_reg.vr[0])
    |=> tx_start && tx_kind == `HALE_FK_RR &&
        $stable(state_reg.ev[`HALE_EV_RME]))
    else $error("sequence error not answered silently");
  // Local busy: I-frame refused with a busy reply
  busy_reject_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (rx_valid && in_auto && rx_kind == `HALE_FK_I && !apb_wr &&
     state_reg.mode[`HALE_MODE_RNR])
    |=> tx_start && tx_kind == `HALE_FK_RNR &&
        $stable(state_reg.ev[`HALE_EV_RME]))
    else $error("busy station accepted an I-frame");
  // Unnumbered frames always reach the host
  u_frame_host_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (rx_valid && rx_kind == `HALE_FK_U && !apb_wr)
    |=> state_reg.ev[`HALE_EV_RME])
    else $error("unnumbered frame not handed to host");
  // Positive ack ends the wait: queue free again, all-sent raised
  ack_release_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (rx_valid && in_auto && rx_kind == `HALE_FK_RR && !apb_wr &&
     state_reg.st == HALE_WAIT_ACK && rx_nr[0] != state_reg.vs[0])
    |=> !state_reg.tx_blocked && state_reg.ev[`HALE_EV_ALL_SENT_EVENT])
    else $error("ack did not release the queue");
endmodule : hale_link_engine

/* verif/hale_remote.sv */
// Remote station model: bytes in, decoded frame headers and bytes out.
// Assumes the engine's line port, all on sys_clk.
`timescale 1ns/1ps
module hale_remote (
  input  wire logic       sys_clk,
  input  wire logic       slow,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  output logic            tx_ready,
  output logic            rx_valid,
  output logic [2:0]      rx_kind,
  output logic            rx_pf,
  output logic [6:0]      rx_ns,
  output logic [6:0]      rx_nr,
  output logic            rx_ifield,
  output logic            rx_byte_valid,
  output logic [7:0]      rx_byte
);
  logic [7:0] pat = 8'h5a;
  logic       hold = 1'b0;
  logic [7:0] got[$];
  initial begin
    tx_ready = 1'b1;
    rx_valid = 1'b0;
    rx_byte_valid = 1'b0;
  end
  // Idle lines carry a moving pattern, so a stale header never matches
  always @(posedge sys_clk) begin
    pat <= pat + 8'h01;
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (tx_valid && tx_ready)
      got.push_back(tx_byte);
    if (!hold) begin
      {rx_kind, rx_pf, rx_ifield} <= pat[4:0];
      rx_ns <= pat[6:0];
      rx_nr <= ~pat[6:0];
      rx_byte <= ~pat;
    end
  end
  // One decoded header, valid for a single cycle
  task automatic send(input logic [2:0] k, input logic pf,
                      input logic [6:0] ns, input logic [6:0] nr);
    @(posedge sys_clk);
    hold <= 1'b1;
    @(posedge sys_clk);
    rx_valid <= 1'b1;
    rx_kind <= k;
    rx_pf <= pf;
    rx_ns <= ns;
    rx_nr <= nr;
    rx_ifield <= 1'b0;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    hold <= 1'b0;
  endtask : send
  // One received byte, valid for a single cycle
  task automatic put(input logic [7:0] b);
    @(posedge sys_clk);
    hold <= 1'b1;
    @(posedge sys_clk);
    rx_byte_valid <= 1'b1;
    rx_byte <= b;
    @(posedge sys_clk);
    rx_byte_valid <= 1'b0;
    hold <= 1'b0;
  endtask : put
endmodule : hale_remote

/* verif/hale_link_engine_tb.sv */
// Self-checking bench for the link engine, APB host plus remote model.
// Assumes hale_consts.svh on the include path.
`timescale 1ns/1ps
`include "hale_consts.svh"
module hale_link_engine_tb;
  logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic slow = 0, pready, pslverr, tx_valid, tx_ready, tx_start;
  logic tx_pf, tx_raw, tx_no_crc, rx_valid, rx_pf, rx_ifield;
  logic rx_byte_valid, s_pf;
  logic [2:0] rx_kind, tx_kind, s_kind;
  logic [6:0] rx_ns, rx_nr, tx_ns, tx_nr, s_ns;
  logic [7:0] paddr = 8'h00, rx_byte, tx_byte, seed = 8'h03;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] exp_q[$];
  int fails = 0, check_count = 0, s_cnt = 0;
  hale_link_engine hale_link_engine_inst (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
    .rx_kind(rx_kind), .rx_pf(rx_pf), .rx_ns(rx_ns), .rx_nr(rx_nr),
    .rx_ifield(rx_ifield), .rx_byte_valid(rx_byte_valid),
    .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_ready(tx_ready), .tx_start(tx_start), .tx_kind(tx_kind),
    .tx_pf(tx_pf), .tx_ns(tx_ns), .tx_nr(tx_nr), .tx_raw(tx_raw),
    .tx_no_crc(tx_no_crc));
  hale_remote hale_remote_inst (
    .sys_clk(sys_clk), .slow(slow), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_kind(rx_kind), .rx_pf(rx_pf), .rx_ns(rx_ns), .rx_nr(rx_nr),
    .rx_ifield(rx_ifield), .rx_byte_valid(rx_byte_valid),
    .rx_byte(rx_byte));
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Latch every frame start the engine launches
  always @(posedge sys_clk) begin
    if (tx_start === 1'b1) begin
      s_cnt <= s_cnt + 1;
      s_kind <= tx_kind;
      s_pf <= tx_pf;
      s_ns <= tx_ns;
    end
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // Acknowledge number for a send number, modulo 8 numbering
  function automatic logic [6:0] ack_of(input logic [6:0] ns);
    return (ns + 7'h01) & 7'h07;
  endfunction : ack_of
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic finish_test;
    if (fails == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  // One APB transfer; read data is taken at the edge that sees pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk("pready", 0, 1);
      finish_test();
    end
  endtask : apb
  // Bounded wait for the next frame start
  task automatic wstart(input int lim);
    int c0, i;
    c0 = s_cnt;
    for (i = 0; i < lim && s_cnt == c0; i++)
      @(posedge sys_clk);
    if (s_cnt == c0) begin
      chk("tx_start", 0, 1);
      finish_test();
    end
  endtask : wstart
  // Bounded wait until the remote has taken n bytes, then compare
  task automatic wbytes(input int n);
    int i;
    for (i = 0; i < 600 && hale_remote_inst.got.size() < n; i++)
      @(posedge sys_clk);
    chk("byte count", hale_remote_inst.got.size(), n);
    foreach (exp_q[j])
      chk("tx_byte", hale_remote_inst.got[j], exp_q[j]);
    hale_remote_inst.got.delete();
    exp_q.delete();
  endtask : wbytes
  task automatic queue_bytes(input int n);
    repeat (n) begin
      seed = lfsr(seed);
      exp_q.push_back(seed);
      apb(1, `HALE_OFF_TXDATA, {24'h0, seed});
    end
  endtask : queue_bytes
  initial begin
    repeat (100000) @(posedge sys_clk);
    chk("run time", 0, 1);
    finish_test();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    // Reset values and an unmapped offset
    apb(0, `HALE_OFF_MODE, 0);
    chk("mode", rd, 32'h0);
    apb(0, `HALE_OFF_TIMER, 0);
    chk("timer", rd, `HALE_TIMER_RESET);
    apb(0, 8'h3c, 0);
    chk("unmapped", rd, 32'h0);
    // Extended transparent, address mode clear: byte in compare register
    apb(1, `HALE_OFF_MODE, 32'h3);
    apb(1, `HALE_OFF_CHANNEL_CONFIG_THREE, 32'h1);
    apb(0, `HALE_OFF_MODE, 0);
    chk("tx_raw", tx_raw, 1);
    chk("tx_no_crc", tx_no_crc, 1);
    repeat (3) begin
      seed = lfsr(seed);
      hale_remote_inst.put(seed);
      apb(0, `HALE_OFF_ADRLOW, 0);
      chk("adr_low", rd[7:0], seed);
    end
    // Address mode set: the byte is also queued, earlier ones were not
    apb(1, `HALE_OFF_MODE, 32'h7);
    seed = lfsr(seed);
    hale_remote_inst.put(seed);
    apb(0, `HALE_OFF_RXDATA, 0);
    chk("rx queue", rd[7:0], seed);
    // Auto mode, internal timer, short retry; far side stalls bytes
    apb(1, `HALE_OFF_CHANNEL_CONFIG_THREE, 0);
    apb(1, `HALE_OFF_MODE, 32'h8);
    apb(1, `HALE_OFF_TIMER, 32'h0001_0001);
    apb(1, `HALE_OFF_EVENT, 32'h7f);
    slow <= 1'b1;
    queue_bytes(3);
    apb(1, `HALE_OFF_CMD, 32'h1);
    wstart(100);
    chk("kind", s_kind, `HALE_FK_I);
    chk("send number", s_ns, 0);
    wbytes(3);
    hale_remote_inst.send(`HALE_FK_RR, 0, 0, ack_of(0));
    repeat (10) @(posedge sys_clk);
    apb(0, `HALE_OFF_EVENT, 0);
    chk("all sent", rd[`HALE_EV_ALL_SENT_EVENT], 1);
    chk("remote change", rd[`HALE_EV_RSC], 0);
    // Second frame left unanswered: poll, then timer expiry
    apb(1, `HALE_OFF_EVENT, 32'h7f);
    queue_bytes(1);
    apb(1, `HALE_OFF_CMD, 32'h1);
    wstart(100);
    chk("send lsb", s_ns[0], 1);
    wbytes(1);
    wstart(300);
    chk("poll kind", s_kind, `HALE_FK_RR);
    chk("poll bit", s_pf, 1);
    repeat (150) @(posedge sys_clk);
    apb(0, `HALE_OFF_EVENT, 0);
    chk("timer expired", rd[`HALE_EV_TIN], 1);
    chk("no all sent", rd[`HALE_EV_ALL_SENT_EVENT], 0);
    // Transparent frame: host queues address and control first
    apb(1, `HALE_OFF_EVENT, 32'h7f);
    slow <= 1'b0;
    queue_bytes(4);
    apb(1, `HALE_OFF_CMD, 32'h2);
    wstart(100);
    chk("kind", s_kind, `HALE_FK_TRANS);
    wbytes(4);
    repeat (4) @(posedge sys_clk);
    apb(0, `HALE_OFF_EVENT, 0);
    chk("pool ready", rd[`HALE_EV_XPR], 1);
    // Unnumbered frame goes to the host
    apb(1, `HALE_OFF_EVENT, 32'h7f);
    hale_remote_inst.send(`HALE_FK_U, 0, 0, 0);
    repeat (4) @(posedge sys_clk);
    apb(0, `HALE_OFF_EVENT, 0);
    chk("frame rx", rd[`HALE_EV_RME], 1);
    // Local busy: I-frame refused silently, busy reply sent
    apb(1, `HALE_OFF_EVENT, 32'h7f);
    apb(1, `HALE_OFF_MODE, 32'h18);
    hale_remote_inst.send(`HALE_FK_I, 0, 0, ack_of(1));
    wstart(100);
    chk("busy reply", s_kind, `HALE_FK_RNR);
    apb(0, `HALE_OFF_EVENT, 0);
    chk("no frame rx", rd[`HALE_EV_RME], 0);
    apb(1, `HALE_OFF_CMD, 32'h4);
    apb(0, `HALE_OFF_STATUS, 0);
    chk("link reset vs", rd[21:15], 0);
    // Out-of-sequence I-frame: RR reply, nothing handed on
    apb(1, `HALE_OFF_MODE, 32'h8);
    hale_remote_inst.send(`HALE_FK_I, 0, 1, 0);
    wstart(100);
    chk("sequence reply", s_kind, `HALE_FK_RR);
    apb(0, `HALE_OFF_EVENT, 0);
    chk("sequence no rx", rd[`HALE_EV_RME], 0);
    finish_test();
  end
endmodule : hale_link_engine_tb
